// ### shared/ros_consts.vh
// constants for the receive overhead serial output port
// assumes a 250 MHz system clock; included by hw/ros_serial_out.v
`ifndef ROS_CONSTS_VH
`define ROS_CONSTS_VH

// =============================================================
// clocking
`define ROS_CLK_NS          4
`define ROS_OVH_HALF_NS     128
`define ROS_OVH_HALF_CYC    (`ROS_OVH_HALF_NS / `ROS_CLK_NS)

// =============================================================
// overhead word layout, msb shifted first
`define ROS_OVH_BITS        16
`define ROS_FAS_MSB         15
`define ROS_FAS_LSB         6
`define ROS_A_BIT           5
`define ROS_N_BIT           4
`define ROS_BIP_MSB         3
`define ROS_BIP_LSB         0

// =============================================================
// buffer and reset values
`define ROS_BUF_DEPTH       2
`define ROS_RST_BIT_CLOCK   1'h1
`define ROS_RST_SERIAL      1'h0

`endif

// ### hw/ros_buf2.v
// small register buffer with valid/ready on both sides
// assumes one clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none

module ros_buf2 #(
  parameter WIDTH = 16,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // fill side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output reg              in_ready,
  // drain side
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  // =============================================================
  // storage
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg [AW:0]      next_count;
  wire            push;
  wire            pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];

  always @* begin
    next_count = count;
    if (push & ~pop) begin
      next_count = count + 1'b1;
    end else if (pop & ~push) begin
      next_count = count - 1'b1;
    end
  end

  // =============================================================
  // pointers; ready is registered so the framer sees a clean level
  always @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr   <= {AW{1'b0}};
      rd_ptr   <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else begin
      count    <= next_count;
      in_ready <= (next_count != DEPTH[AW:0]);
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

`default_nettype wire

// ### hw/ros_serial_out.v
// receive overhead serial output port: shifts each frame's overhead word out
// assumes overhead words arrive from the framer on clk_sys with valid/ready,
// and that line_recv_clock is an asynchronous pin sampled here;
// the strobe needs a bit period longer than two line periods, and both
// access methods run side by side with no method select
//
// Functional notes
// - overhead is offered both on the self-made bit clock and on the line clock with a strobe.
// - frame start is high for exactly one bit-clock period, with the first overhead bit.
// - frame start is low at every other time.
// - frame start changes only at falling edges of the bit clock.
// - the strobe is high for exactly one line clock period while serial data is stable.
// - the strobe is low except during those single-period pulses.
// - the strobe serves only the line-clock method and means nothing in the other.
// - serial data changes only at bit-clock falling edges and the bit clock never stops.
// - per frame ten alignment bits msb first, then A, N and four BIP-4 bits go out.
// - the serial output is always active with no disable of any kind.
`timescale 1ns/100ps
`default_nettype none
`include "ros_consts.vh"

module ros_serial_out #(
  parameter OVH_HALF_CYC = `ROS_OVH_HALF_CYC,
  parameter WORD_W       = `ROS_OVH_BITS
) (
  // clock and reset
  input  wire              clk_sys,
  input  wire              rst,
  // line clock pin
  input  wire              line_recv_clock,
  // overhead words from the framer
  input  wire [WORD_W-1:0] ovh_word,
  input  wire              ovh_word_valid,
  output wire              ovh_word_ready,
  // serial port pins
  output reg               ovh_bit_clock,
  output reg               ovh_serial_out,
  output reg               ovh_frame_start,
  output reg               ovh_sample_strobe
);

  // position counter width follows the word width
  function integer ros_clog2;
    input integer value;
    integer v;
    begin
      v = value - 1;
      ros_clog2 = 0;
      while (v > 0) begin
        ros_clog2 = ros_clog2 + 1;
        v = v >> 1;
      end
    end
  endfunction

  localparam             DIV_W      = 16;
  localparam             POS_W      = ros_clog2(WORD_W);
  localparam integer     DIV_LAST_I = OVH_HALF_CYC - 1;
  localparam integer     POS_LAST_I = WORD_W - 1;
  localparam [DIV_W-1:0] DIV_LAST   = DIV_LAST_I[DIV_W-1:0];
  localparam [POS_W-1:0] POS_LAST   = POS_LAST_I[POS_W-1:0];

  // =============================================================
  // two-entry buffer so a late shifter never drops a word
  wire [WORD_W-1:0] buf_data;
  wire              buf_valid;
  wire              buf_ready;

  ros_buf2 #(
    .WIDTH (WORD_W),
    .DEPTH (`ROS_BUF_DEPTH),
    .AW    (1)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (ovh_word),
    .in_valid  (ovh_word_valid),
    .in_ready  (ovh_word_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready)
  );

  // =============================================================
  // bit clock divider, free running from reset release;
  // resets high so the first fall comes a full half period after reset
  reg [DIV_W-1:0] div_cnt;
  wire            div_wrap;
  wire            fall_evt;

  assign div_wrap = (div_cnt == DIV_LAST);
  assign fall_evt = div_wrap & ovh_bit_clock;

  always @(posedge clk_sys) begin
    if (rst) begin
      div_cnt       <= {DIV_W{1'b0}};
      ovh_bit_clock <= `ROS_RST_BIT_CLOCK;
    end else if (div_wrap) begin
      div_cnt       <= {DIV_W{1'b0}};
      ovh_bit_clock <= ~ovh_bit_clock; // never gated
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // =============================================================
  // shifter: loads a word only at a word boundary, so a word that
  // arrives mid-frame waits in the buffer instead of cutting one short
  reg [WORD_W-1:0] shreg;
  reg [POS_W-1:0]  bit_pos;
  reg              active;
  reg [WORD_W-1:0] next_shreg;
  reg [POS_W-1:0]  next_bit_pos;
  reg              next_active;
  reg              next_serial;
  reg              next_frame_start;
  wire             at_boundary;

  assign at_boundary = ~active | (bit_pos == POS_LAST);
  assign buf_ready   = fall_evt & at_boundary;

  always @* begin
    next_shreg       = shreg;
    next_bit_pos     = bit_pos;
    next_active      = active;
    next_serial      = ovh_serial_out;
    next_frame_start = ovh_frame_start;
    if (fall_evt) begin
      if (at_boundary) begin
        next_bit_pos = {POS_W{1'b0}};
        if (buf_valid) begin
          next_shreg       = buf_data;
          next_active      = 1'b1;
          next_serial      = buf_data[WORD_W-1]; // alignment msb first
          next_frame_start = 1'b1;
        end else begin
          // no word ready: idle low, port stays driven
          next_active      = 1'b0;
          next_serial      = 1'b0;
          next_frame_start = 1'b0;
        end
      end else begin
        next_bit_pos     = bit_pos + 1'b1;
        next_shreg       = {shreg[WORD_W-2:0], 1'b0};
        next_serial      = shreg[WORD_W-2];
        next_frame_start = 1'b0;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      shreg           <= {WORD_W{1'b0}};
      bit_pos         <= {POS_W{1'b0}};
      active          <= 1'b0;
      ovh_serial_out  <= `ROS_RST_SERIAL;
      ovh_frame_start <= 1'b0;
    end else begin
      shreg           <= next_shreg;
      bit_pos         <= next_bit_pos;
      active          <= next_active;
      ovh_serial_out  <= next_serial;
      ovh_frame_start <= next_frame_start;
    end
  end

  // =============================================================
  // line clock: synchronise, then find rising edges;
  // a pin already high at reset makes one false rise, harmless as nothing is pending
  reg line_meta;
  reg line_sync;
  reg line_prev;
  wire line_rise;

  assign line_rise = line_sync & ~line_prev;

  always @(posedge clk_sys) begin
    if (rst) begin
      line_meta <= 1'b0;
      line_sync <= 1'b0;
      line_prev <= 1'b0;
    end else begin
      line_meta <= line_recv_clock;
      line_sync <= line_meta;
      line_prev <= line_sync;
    end
  end

  // =============================================================
  // sample strobe: one line period, starting at the first line edge
  // after a bit update; needs a bit period of over two line periods,
  // since a strobe still high at the next bit update is cut short
  localparam [1:0] STB_IDLE = 2'b00;
  localparam [1:0] STB_WAIT = 2'b01;
  localparam [1:0] STB_HIGH = 2'b10;

  reg  [1:0] stb_state;
  reg  [1:0] next_stb_state;
  wire       bit_is_data;

  // idle fill bits carry no overhead, so they get no strobe
  assign bit_is_data = at_boundary ? buf_valid : 1'b1;

  always @* begin
    next_stb_state = stb_state;
    if (fall_evt) begin
      next_stb_state = bit_is_data ? STB_WAIT : STB_IDLE; // never spans a change
    end else if (line_rise) begin
      case (stb_state)
        STB_WAIT: next_stb_state = STB_HIGH;
        STB_HIGH: next_stb_state = STB_IDLE;
        STB_IDLE: next_stb_state = STB_IDLE;
        default:  next_stb_state = STB_IDLE;
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      stb_state         <= STB_IDLE;
      ovh_sample_strobe <= 1'b0;
    end else begin
      stb_state         <= next_stb_state;
      ovh_sample_strobe <= (next_stb_state == STB_HIGH);
    end
  end

endmodule

`default_nettype wire

// ### testbench/ros_serial_out_sva.sv
// pin timing checks for the overhead serial port
// assumes binding to ros_serial_out; line clock period LINE_CYC clk_sys cycles
`timescale 1ns/100ps
`default_nettype none
// ========
// checker
module ros_serial_out_sva #(
  parameter int OVH_HALF_CYC = 16,
  parameter int LINE_CYC     = 12
) (
  // clock and pins
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic line_recv_clock,
  input wire logic ovh_bit_clock,
  input wire logic ovh_serial_out,
  input wire logic ovh_frame_start,
  input wire logic ovh_sample_strobe
);
  logic [7:0] bc_n;
  logic [7:0] fs_n;
  logic [7:0] st_n;
  logic       bc_q;
  logic       seen;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // the first half period after reset is not checked exactly
  always_ff @(posedge clk_sys) begin
    bc_q <= ovh_bit_clock;
    if (rst) begin
      bc_n <= 8'h00;
      fs_n <= 8'h00;
      st_n <= 8'h00;
      seen <= 1'b0;
    end else begin
      bc_n <= (ovh_bit_clock != bc_q) ? 8'h00 : bc_n + 8'h01;
      seen <= seen | (ovh_bit_clock != bc_q);
      fs_n <= ovh_frame_start ? fs_n + 8'h01 : 8'h00;
      st_n <= ovh_sample_strobe ? st_n + 8'h01 : 8'h00;
    end
  end
  a_fs_on_fall: assert property ($changed(ovh_frame_start) |-> $fell(ovh_bit_clock))
    else $error("frame start moved off a bit clock fall");
  a_data_on_fall: assert property ($changed(ovh_serial_out) |-> $fell(ovh_bit_clock))
    else $error("serial data moved off a bit clock fall");
  a_fs_width: assert property ($fell(ovh_frame_start) |-> fs_n == 2 * OVH_HALF_CYC)
    else $error("frame start not one bit period wide");
  a_clk_half: assert property (seen && $changed(ovh_bit_clock) |-> bc_n == OVH_HALF_CYC - 1)
    else $error("bit clock half period wrong");
  a_clk_runs: assert property (bc_n <= OVH_HALF_CYC + 2)
    else $error("bit clock stopped");
  a_strobe_len: assert property ($fell(ovh_sample_strobe) |-> st_n <= LINE_CYC)
    else $error("strobe longer than a line period");
  a_strobe_stable: assert property (
    ovh_sample_strobe |-> $stable(ovh_serial_out) && $stable(ovh_frame_start))
    else $error("data moved under the strobe");
  a_strobe_line: assert property ($rose(ovh_sample_strobe) |-> $past(line_recv_clock))
    else $error("strobe not after a line clock rise");
endmodule
`default_nettype wire

// ### testbench/ros_term_model.sv
// terminal equipment model: collects overhead words by both methods
// assumes line_recv_clock is made by the bench
`timescale 1ns/100ps
`default_nettype none
// ========
// receiver
module ros_term_model (
  // port pins
  input wire logic ovh_bit_clock,
  input wire logic ovh_serial_out,
  input wire logic ovh_frame_start,
  input wire logic ovh_sample_strobe,
  input wire logic line_recv_clock
);
  logic [15:0] m1_q[$];
  logic [15:0] m2_q[$];
  logic [15:0] sh1;
  logic [15:0] sh2;
  int          n1 = 16;
  int          n2 = 16;
  // bits before the first frame start are ignored
  always @(posedge ovh_bit_clock) begin
    if (ovh_frame_start === 1'b1) n1 = 0;
    if (n1 < 16) begin
      sh1 = {sh1[14:0], ovh_serial_out};
      n1++;
      if (n1 == 16) m1_q.push_back(sh1);
    end
  end
  always @(negedge line_recv_clock) begin
    if (ovh_sample_strobe === 1'b1) begin
      if (ovh_frame_start === 1'b1) n2 = 0;
      if (n2 < 16) begin
        sh2 = {sh2[14:0], ovh_serial_out};
        n2++;
        if (n2 == 16) m2_q.push_back(sh2);
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/ros_serial_out_tb_top.sv
// bench top for ros_serial_out with terminal model and checker
// assumes include path shared/ for the design
`timescale 1ns/100ps
`default_nettype none
// ========
// bench
module ros_serial_out_tb_top;
  localparam int H = 16;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        line_recv_clock = 1'b0;
  logic [15:0] ovh_word = 16'h0000;
  logic        ovh_word_valid = 1'b0;
  wire         ovh_word_ready;
  wire         ovh_bit_clock;
  wire         ovh_serial_out;
  wire         ovh_frame_start;
  wire         ovh_sample_strobe;
  int          fails = 0;
  int          n_compared = 0;
  int          seed = 32'hED1A75AA;
  logic [15:0] exp_q[$];
  always #2 clk_sys = ~clk_sys;
  initial begin
    #1.3;
    forever #24 line_recv_clock = ~line_recv_clock;
  end
  ros_serial_out #(.OVH_HALF_CYC(H)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .line_recv_clock(line_recv_clock), .ovh_word(ovh_word), .ovh_word_valid(ovh_word_valid),
    .ovh_word_ready(ovh_word_ready), .ovh_bit_clock(ovh_bit_clock),
    .ovh_serial_out(ovh_serial_out), .ovh_frame_start(ovh_frame_start),
    .ovh_sample_strobe(ovh_sample_strobe));
  ros_term_model i_term (.ovh_bit_clock(ovh_bit_clock), .ovh_serial_out(ovh_serial_out),
    .ovh_frame_start(ovh_frame_start), .ovh_sample_strobe(ovh_sample_strobe),
    .line_recv_clock(line_recv_clock));
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t level %b expected %b", $time, got, exp);
    end
  endtask
  // far-end bit order: bit n after the frame start carries word bit 15-n
  function automatic logic [15:0] exp_serial(input logic [15:0] w);
    logic [15:0] r;
    r = 16'h0000;
    for (int n = 0; n < 16; n++) begin
      r = {r[14:0], w[15 - n]};
    end
    return r;
  endfunction
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // valid stays up between words so the buffer fills and refuses
  task automatic run_batch(input int n, input string name);
    logic [15:0] w;
    int t;
    for (int i = 0; i < n; i++) begin
      w = (i == 0) ? 16'hFFC0 : (i == 1) ? 16'h003F : 16'($random(seed));
      ovh_word = w;
      ovh_word_valid = 1'b1;
      exp_q.push_back(exp_serial(w));
      if (i == 0) chk1(ovh_word_ready, 1'b1);
      if (i == 2) chk1(ovh_word_ready, 1'b0);
      t = 0;
      while (ovh_word_ready !== 1'b1 && t < 2000) begin
        @(negedge clk_sys);
        t++;
      end
      if (t >= 2000) begin
        fails++;
        $display("[ERR] %0t word never taken", $time);
      end
      @(negedge clk_sys);
    end
    ovh_word_valid = 1'b0;
    t = 0;
    while (i_term.m2_q.size() < exp_q.size() && t < 20000) begin
      @(negedge clk_sys);
      t++;
    end
    if (t >= 20000) begin
      fails++;
      $display("[ERR] %0t strobed words missing", $time);
    end
    repeat (4 * H) @(negedge clk_sys);
    chk16(16'(i_term.m1_q.size()), 16'(exp_q.size()));
    chk16(16'(i_term.m2_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) begin
      chk16(i_term.m1_q[i], exp_q[i]);
      chk16(i_term.m2_q[i], exp_q[i]);
    end
    exp_q.delete();
    i_term.m1_q.delete();
    i_term.m2_q.delete();
    $display("test %s done", name);
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    run_batch(10, "burst");
    run_batch(1, "single");
    finish_test();
  end
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule
bind ros_serial_out ros_serial_out_sva #(.OVH_HALF_CYC(OVH_HALF_CYC)) i_sva (
  .clk_sys(clk_sys), .rst(rst), .line_recv_clock(line_recv_clock),
  .ovh_bit_clock(ovh_bit_clock), .ovh_serial_out(ovh_serial_out),
  .ovh_frame_start(ovh_frame_start), .ovh_sample_strobe(ovh_sample_strobe));
`default_nettype wire
